/* File: flash_cmd_defines.vh */
`ifndef FLASH_CMD_DEFINES_VH
`define FLASH_CMD_DEFINES_VH
`define OP_READ 8'h03
`define OP_FAST_READ 8'h0b
`define OP_SECTOR_ERASE 8'h20
`define OP_BLOCK_ERASE 8'h52
`define OP_CHIP_ERASE_A 8'h60
`define OP_CHIP_ERASE_B 8'hc7
`define OP_BYTE_PROG 8'h02
`define OP_AUTO_INC_PROG 8'had
`define OP_STATUS_READ 8'h05
`define OP_STATUS_WRITE_UNLOCK 8'h50
`define OP_STATUS_WRITE 8'h01
`define OP_WRITE_LATCH_SET 8'h06
`define OP_WRITE_LATCH_CLEAR 8'h04
`define OP_IDENT_READ_A 8'h90
`define OP_IDENT_READ_B 8'hab
`define OP_READY_OUT_ON 8'h70
`define OP_READY_OUT_OFF 8'h80
`define OP_PAUSE_PIN_SELECT 8'haa
`define ST_BIT_BUSY 0
`define ST_BIT_WEL 1
`define ST_BIT_PROT_LOW 2
`define ST_BIT_PROT_MID 3
`define ST_BIT_PROT_TOP 4
`define ST_BIT_AUTO_INC 6
`define ST_BIT_LOCK 7
`define PROT_LEVEL_RESET 3'h3
`define DENS_512K 2'h0
`define DENS_1M 2'h1
`define DENS_2M 2'h2
`define DENS_4M 2'h3
`endif

/* File: serial_flash_protect_cmd_decode.v */
// Summary of operation
// - Status flag shows auto-increment mode, reset single-byte.
// - Writes into protected region are rejected.
// - Status write updates levels when guard high/unlocked.
// - Whole-array erase only when all levels zero.
// - Guard low and lock set freezes lock, levels.
// - Guard high makes lock bit irrelevant.
// - Lock bit clears at power-up.
// - Lower two levels power up as 11.
// - 512K codes guard quarter, half, all.
// - 1M codes guard quarter, half, all.
// - 4M three-bit codes: eighth, quarter, half, all.
// - Every opcode, address, data cycle eight bits.
// - Decode starts at select fall, rising edges, MSB first.
// - Early select rise aborts instruction to standby.
// - Reads 03 and 0B, streamed until deselect.
// - 20 sector erase, 52 block erase, three addresses.
// - 60 or C7 erase whole array.
// - 02 single byte; AD auto-increment, two bytes each.
// - 90 or AB identification read streams bytes.
// - 70 enables, 80 disables ready report on output.
// - AA switches shared pin to hold function.
// - Write latch clears at reset and write completion.
// - Lock flag is status bit 7.
// - Status read repeats until select rises.
`include "flash_cmd_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module serial_flash_protect_cmd_decode #(
    parameter [1:0] DENSITY = `DENS_4M,
    parameter [7:0] MAKER_ID = 8'h5a,
    parameter [7:0] PART_ID = 8'ha5
) (
    // Clock, reset and enable.
    input wire clk_sys,
    input wire reset_n,
    input wire clk_en,
    // Serial link pins.
    input wire sel_n_pin,
    input wire sck_pin,
    input wire sdi_pin,
    output reg sdo_out,
    output reg sdo_oe_n,
    // Guard pin and array side.
    input wire write_guard_pin,
    input wire array_busy,
    input wire [7:0] array_rdata,
    output reg [23:0] array_addr,
    output reg [7:0] array_wdata,
    output reg array_rd,
    output reg array_prog,
    output reg array_sector_erase,
    output reg array_block_erase,
    output reg array_chip_erase,
    output reg write_rejected,
    // Status and mode.
    output wire [7:0] status_byte,
    output reg ready_out_en,
    output reg pause_pin_mode
);
    localparam S_IDLE = 6'h01;
    localparam S_OPC = 6'h02;
    localparam S_ADDR = 6'h04;
    localparam S_DUMMY = 6'h08;
    localparam S_DATA = 6'h10;
    localparam S_OUT = 6'h20;

    reg [2:0] sel_sync_q, sck_sync_q, sdi_sync_q;
    reg guard_sync_q, guard_q;
    reg [5:0] state_q;
    reg [7:0] shift_q, opcode_q, tx_q, wbuf_q;
    reg [2:0] bit_q;
    reg [1:0] acnt_q;
    reg [23:0] addr_q;
    reg wel_q, lock_q, auto_inc_q, sw_unlock_q, aai_half_q, have_data_q;
    reg [2:0] prot_q;

    wire sel_n = sel_sync_q[1];
    wire sck_rise = sck_sync_q[1] & ~sck_sync_q[2];
    wire sck_fall = ~sck_sync_q[1] & sck_sync_q[2];
    wire sel_fall = ~sel_sync_q[1] & sel_sync_q[2];
    wire sel_rise = sel_sync_q[1] & ~sel_sync_q[2];
    wire [7:0] byte_in = {shift_q[6:0], sdi_sync_q[1]};
    wire byte_done = sck_rise & (bit_q == 3'h7);
    // Level and lock bits may change only when guard high or lock clear.
    wire write_guard_pin_ok = guard_q | ~lock_q;
    wire st_write_ok = write_guard_pin_ok;

    assign status_byte = {lock_q, auto_inc_q, 1'b0, prot_q,
                          wel_q, array_busy};

    // Protected region test for each density.
    reg prot_hit;
    always @*
    begin
        prot_hit = 1'b0;
        case (DENSITY)
            `DENS_512K:
                case (prot_q[1:0])
                    2'h1: prot_hit = addr_q[15:14] == 2'h3;
                    2'h2: prot_hit = addr_q[15];
                    2'h3: prot_hit = 1'b1;
                    default: prot_hit = 1'b0;
                endcase
            `DENS_1M:
                case (prot_q[1:0])
                    2'h1: prot_hit = addr_q[16:15] == 2'h3;
                    2'h2: prot_hit = addr_q[16];
                    2'h3: prot_hit = 1'b1;
                    default: prot_hit = 1'b0;
                endcase
            `DENS_2M:
                case (prot_q[1:0])
                    2'h1: prot_hit = addr_q[17:16] == 2'h3;
                    2'h2: prot_hit = addr_q[17];
                    2'h3: prot_hit = 1'b1;
                    default: prot_hit = 1'b0;
                endcase
            default:
                case (prot_q)
                    3'h0: prot_hit = 1'b0;
                    3'h1: prot_hit = addr_q[18:16] == 3'h7;
                    3'h2: prot_hit = addr_q[18:17] == 2'h3;
                    3'h3: prot_hit = addr_q[18];
                    default: prot_hit = 1'b1;
                endcase
        endcase
    end

    wire is_prog_op = (opcode_q == `OP_BYTE_PROG) |
                      (opcode_q == `OP_AUTO_INC_PROG);
    wire is_erase_op = (opcode_q == `OP_SECTOR_ERASE) |
                       (opcode_q == `OP_BLOCK_ERASE);
    wire is_read_op = (opcode_q == `OP_READ) |
                      (opcode_q == `OP_FAST_READ);
    wire is_id_op = (opcode_q == `OP_IDENT_READ_A) |
                    (opcode_q == `OP_IDENT_READ_B);

    always @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sel_sync_q <= 3'h7;
            sck_sync_q <= 3'h0;
            sdi_sync_q <= 3'h0;
            guard_sync_q <= 1'b0;
            guard_q <= 1'b0;
            state_q <= S_IDLE;
            shift_q <= 8'h00;
            opcode_q <= 8'h00;
            tx_q <= 8'h00;
            wbuf_q <= 8'h00;
            bit_q <= 3'h0;
            acnt_q <= 2'h0;
            addr_q <= 24'h000000;
            wel_q <= 1'b0;
            lock_q <= 1'b0;
            prot_q <= `PROT_LEVEL_RESET;
            auto_inc_q <= 1'b0;
            sw_unlock_q <= 1'b0;
            aai_half_q <= 1'b0;
            have_data_q <= 1'b0;
            ready_out_en <= 1'b0;
            pause_pin_mode <= 1'b0;
            sdo_out <= 1'b0;
            sdo_oe_n <= 1'b1;
            array_addr <= 24'h000000;
            array_wdata <= 8'h00;
            array_rd <= 1'b0;
            array_prog <= 1'b0;
            array_sector_erase <= 1'b0;
            array_block_erase <= 1'b0;
            array_chip_erase <= 1'b0;
            write_rejected <= 1'b0;
        end
        else if (clk_en)
        begin
            sel_sync_q <= {sel_sync_q[1:0], sel_n_pin};
            sck_sync_q <= {sck_sync_q[1:0], sck_pin};
            sdi_sync_q <= {sdi_sync_q[1:0], sdi_pin};
            guard_sync_q <= write_guard_pin;
            guard_q <= guard_sync_q;
            array_rd <= 1'b0;
            array_prog <= 1'b0;
            array_sector_erase <= 1'b0;
            array_block_erase <= 1'b0;
            array_chip_erase <= 1'b0;
            write_rejected <= 1'b0;
            if (sck_rise && !sel_n)
            begin
                shift_q <= byte_in;
                bit_q <= bit_q + 3'h1;
            end
            if (sel_fall)
            begin
                state_q <= S_OPC;
                bit_q <= 3'h0;
                have_data_q <= 1'b0;
            end
            else if (sel_rise)
            begin
                // Sector and block erase finish at deselect; partial
                // bytes abort.
                if (bit_q == 3'h0 && state_q == S_DATA && have_data_q)
                begin
                    if (opcode_q == `OP_BYTE_PROG ||
                        opcode_q == `OP_AUTO_INC_PROG)
                        wel_q <= auto_inc_q &
                                 (opcode_q == `OP_AUTO_INC_PROG);
                end
                if (bit_q == 3'h0 && state_q == S_ADDR && acnt_q == 2'h3)
                begin
                    if (!wel_q || prot_hit)
                        write_rejected <= 1'b1;
                    else
                    begin
                        array_addr <= addr_q;
                        array_sector_erase <=
                            opcode_q == `OP_SECTOR_ERASE;
                        array_block_erase <=
                            opcode_q == `OP_BLOCK_ERASE;
                    end
                    wel_q <= 1'b0;
                end
                state_q <= S_IDLE;
                sdo_oe_n <= 1'b1;
                bit_q <= 3'h0;
            end
            else if (byte_done && !sel_n)
            begin
                case (state_q)
                    S_OPC:
                    begin
                        opcode_q <= byte_in;
                        acnt_q <= 2'h0;
                        state_q <= S_IDLE;
                        case (byte_in)
                            `OP_READ, `OP_FAST_READ, `OP_SECTOR_ERASE,
                            `OP_BLOCK_ERASE, `OP_BYTE_PROG,
                            `OP_AUTO_INC_PROG, `OP_IDENT_READ_A,
                            `OP_IDENT_READ_B:
                                state_q <= S_ADDR;
                            `OP_STATUS_WRITE:
                                state_q <= S_DATA;
                            `OP_STATUS_READ:
                            begin
                                tx_q <= status_byte;
                                state_q <= S_OUT;
                            end
                            `OP_WRITE_LATCH_SET:
                                wel_q <= 1'b1;
                            `OP_WRITE_LATCH_CLEAR:
                                wel_q <= 1'b0;
                            `OP_STATUS_WRITE_UNLOCK:
                                sw_unlock_q <= 1'b1;
                            `OP_CHIP_ERASE_A, `OP_CHIP_ERASE_B:
                            begin
                                if (wel_q && prot_q == 3'h0)
                                    array_chip_erase <= 1'b1;
                                else
                                    write_rejected <= 1'b1;
                                wel_q <= 1'b0;
                            end
                            `OP_READY_OUT_ON:
                                ready_out_en <= 1'b1;
                            `OP_READY_OUT_OFF:
                                ready_out_en <= 1'b0;
                            `OP_PAUSE_PIN_SELECT:
                                pause_pin_mode <= 1'b1;
                            default:
                                state_q <= S_IDLE;
                        endcase
                    end
                    S_ADDR:
                    begin
                        addr_q <= {addr_q[15:0], byte_in};
                        acnt_q <= acnt_q + 2'h1;
                        if (acnt_q == 2'h2)
                        begin
                            if (opcode_q == `OP_FAST_READ)
                                state_q <= S_DUMMY;
                            else if (is_prog_op)
                                state_q <= S_DATA;
                            else if (is_read_op)
                            begin
                                array_addr <= {addr_q[15:0], byte_in};
                                array_rd <= 1'b1;
                                state_q <= S_OUT;
                            end
                            else if (is_id_op)
                            begin
                                tx_q <= byte_in[0] ? PART_ID : MAKER_ID;
                                addr_q <= {addr_q[15:0], byte_in};
                                state_q <= S_OUT;
                            end
                        end
                    end
                    S_DUMMY:
                    begin
                        array_addr <= addr_q;
                        array_rd <= 1'b1;
                        state_q <= S_OUT;
                    end
                    S_DATA:
                    begin
                        have_data_q <= 1'b1;
                        if (opcode_q == `OP_STATUS_WRITE)
                        begin
                            if ((wel_q || sw_unlock_q) && st_write_ok)
                            begin
                                prot_q[1:0] <= byte_in[3:2];
                                lock_q <= byte_in[`ST_BIT_LOCK];
                                if (DENSITY == `DENS_4M)
                                    prot_q[2] <= byte_in[4];
                            end
                            wel_q <= 1'b0;
                            sw_unlock_q <= 1'b0;
                            state_q <= S_IDLE;
                        end
                        else if (!wel_q || prot_hit)
                        begin
                            write_rejected <= 1'b1;
                            auto_inc_q <= 1'b0;
                            wel_q <= 1'b0;
                            state_q <= S_IDLE;
                        end
                        else if (opcode_q == `OP_BYTE_PROG)
                        begin
                            array_addr <= addr_q;
                            array_wdata <= byte_in;
                            array_prog <= 1'b1;
                            wel_q <= 1'b0;
                            state_q <= S_IDLE;
                        end
                        else
                        begin
                            // Auto-increment: even then odd byte.
                            array_addr <= {addr_q[23:1], aai_half_q};
                            array_wdata <= byte_in;
                            array_prog <= 1'b1;
                            auto_inc_q <= 1'b1;
                            aai_half_q <= ~aai_half_q;
                            if (aai_half_q)
                                addr_q <= {addr_q[23:1] + 23'h1, 1'b0};
                        end
                    end
                    S_OUT:
                    begin
                        if (opcode_q == `OP_STATUS_READ)
                            tx_q <= status_byte;
                        else if (is_id_op)
                        begin
                            addr_q[0] <= ~addr_q[0];
                            tx_q <= addr_q[0] ? MAKER_ID : PART_ID;
                        end
                        else
                        begin
                            addr_q <= addr_q + 24'h1;
                            array_addr <= addr_q + 24'h1;
                            array_rd <= 1'b1;
                        end
                    end
                    default:
                        state_q <= S_IDLE;
                endcase
            end
            if (state_q == S_OUT && !sel_n && sck_fall)
            begin
                sdo_oe_n <= 1'b0;
                if (is_read_op && bit_q == 3'h0)
                begin
                    sdo_out <= array_rdata[7];
                    tx_q <= {array_rdata[6:0], 1'b0};
                end
                else
                begin
                    sdo_out <= tx_q[7];
                    tx_q <= {tx_q[6:0], 1'b0};
                end
            end
            if (!array_busy && auto_inc_q && state_q == S_IDLE &&
                opcode_q == `OP_WRITE_LATCH_CLEAR)
            begin
                auto_inc_q <= 1'b0;
                aai_half_q <= 1'b0;
            end
        end
    end
endmodule // serial_flash_protect_cmd_decode
`default_nettype wire

/* File: serial_flash_protect_cmd_decode_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module flash_decode_checker #(
    parameter [1:0] DENSITY = 2'h3
) (
    // Clock, reset and pins.
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic sel_n_pin,
    input wire logic write_guard_pin,
    input wire logic sdo_oe_n,
    // Decoder outputs.
    input wire logic [23:0] array_addr,
    input wire logic array_prog,
    input wire logic array_sector_erase,
    input wire logic array_block_erase,
    input wire logic array_chip_erase,
    input wire logic write_rejected,
    input wire logic [7:0] status_byte
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    wire logic erase_op;
    wire logic wr_op;
    assign erase_op = array_sector_erase | array_block_erase | array_chip_erase;
    assign wr_op = erase_op | array_prog;
    // Tells whether an address falls in the guarded upper part of the array.
    function automatic logic hit(input logic [23:0] a, input logic [2:0] p);
        int k;
        if (DENSITY == 2'h3 ? p == 3'h0 : p[1:0] == 2'h0)
            return 1'b0;
        k = (DENSITY == 2'h3) ? (p[2] ? 0 : 4 - p[1:0]) : 3 - p[1:0];
        for (int i = 0; i < k; i++)
            if (!a[15 + DENSITY - i])
                return 1'b0;
        return 1'b1;
    endfunction
    AST_RESET_STATE: assert property (
        $rose(reset_n) |-> status_byte[7:1] == 7'h06)
        else $error("status not at power-up value");
    AST_CHIP_ERASE_OPEN: assert property (
        array_chip_erase |-> status_byte[4:2] == 3'h0)
        else $error("chip erase while protected");
    AST_WRITE_NEEDS_LATCH: assert property (
        wr_op |-> status_byte[1] || $past(status_byte[1]))
        else $error("write without latch");
    AST_PROG_OUTSIDE: assert property (
        array_prog |-> !hit(array_addr, status_byte[4:2]))
        else $error("program into guarded area");
    AST_REJECT_ALONE: assert property (
        write_rejected |-> !wr_op)
        else $error("refused write still executed");
    AST_LOCK_FROZEN: assert property (
        (!write_guard_pin)[*5] ##0 status_byte[7] |=>
        status_byte[7] && $stable(status_byte[3:2]))
        else $error("locked bits changed");
    AST_ERASE_CLEARS_LATCH: assert property (
        erase_op |-> ##[0:3] !status_byte[1])
        else $error("latch kept after erase");
    AST_IDLE_RELEASED: assert property (
        sel_n_pin[*6] |-> sdo_oe_n)
        else $error("output driven while deselected");
    AST_PROG_PULSE: assert property (
        $rose(array_prog) |=> !array_prog)
        else $error("program pulse too long");
endmodule // flash_decode_checker
bind serial_flash_protect_cmd_decode flash_decode_checker #(
    .DENSITY(DENSITY)
) u_chk (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .sel_n_pin(sel_n_pin),
    .write_guard_pin(write_guard_pin),
    .sdo_oe_n(sdo_oe_n),
    .array_addr(array_addr),
    .array_prog(array_prog),
    .array_sector_erase(array_sector_erase),
    .array_block_erase(array_block_erase),
    .array_chip_erase(array_chip_erase),
    .write_rejected(write_rejected),
    .status_byte(status_byte)
);
`default_nettype wire

/* File: serial_flash_protect_cmd_decode_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_defines.vh"
module serial_flash_protect_cmd_decode_tb;
    localparam [7:0] MAKER = 8'h3c; // Arbitrary value.
    localparam [7:0] PART = 8'hc3; // Arbitrary value.
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic write_guard_pin = 1'b1;
    logic array_busy = 1'b0;
    logic [7:0] array_rdata = 8'h00;
    wire logic sel_n_pin, sck_pin, sdi_pin, sdo_out, sdo_oe_n;
    wire logic [23:0] array_addr;
    wire logic [7:0] array_wdata, status_byte;
    wire logic array_rd, array_prog, array_sector_erase, array_block_erase;
    wire logic array_chip_erase, write_rejected, ready_out_en, pause_pin_mode;
    int mismatches = 0, n_checks = 0, seed = 85114;
    int n_prog, n_rej, n_er;
    logic [23:0] last_addr;
    logic [7:0] last_wdata, exp_st = 8'h0c;
    logic [7:0] rd_q[$];
    logic [47:0] er_tab[5] = '{48'h60, 48'h60, 48'hc7, 48'h20012345,
        48'h52012345};
    int er_exp[5] = '{0, 1, 1, 2, 4};
    logic [7:0] md_op[3] = '{8'h70, 8'h80, 8'haa};
    logic [1:0] md_exp[3] = '{2'b10, 2'b00, 2'b01};
    always #20 clk_sys = ~clk_sys;
    serial_flash_protect_cmd_decode #(
        .DENSITY(`DENS_4M),
        .MAKER_ID(MAKER),
        .PART_ID(PART)
    ) dut (
        .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(1'b1),
        .sel_n_pin(sel_n_pin), .sck_pin(sck_pin), .sdi_pin(sdi_pin),
        .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n),
        .write_guard_pin(write_guard_pin), .array_busy(array_busy),
        .array_rdata(array_rdata), .array_addr(array_addr),
        .array_wdata(array_wdata), .array_rd(array_rd),
        .array_prog(array_prog), .array_sector_erase(array_sector_erase),
        .array_block_erase(array_block_erase),
        .array_chip_erase(array_chip_erase),
        .write_rejected(write_rejected), .status_byte(status_byte),
        .ready_out_en(ready_out_en), .pause_pin_mode(pause_pin_mode)
    );
    spi_host_model host (.clk_sys(clk_sys), .sel_n_pin(sel_n_pin),
        .sck_pin(sck_pin), .sdi_pin(sdi_pin), .sdo_out(sdo_out),
        .sdo_oe_n(sdo_oe_n));
    always @(posedge clk_sys)
    begin
        n_prog += int'(array_prog);
        n_rej += int'(write_rejected);
        n_er += int'({array_block_erase, array_sector_erase, array_chip_erase});
        if (array_prog)
            last_wdata = array_wdata;
        if (array_prog || array_rd)
            last_addr = array_addr;
    end
    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp,
        input string what);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: %s %h not %h", $time, what, got, exp);
        end
    endtask
    task automatic xact(input int n, input logic [47:0] b, input int nr);
        logic [7:0] r;
        host.start();
        for (int i = n - 1; i >= 0; i--)
            host.shift(b[8 * i +: 8], 8, r);
        rd_q.delete();
        for (int i = 0; i < nr; i++)
        begin
            host.shift(8'h00, 8, r);
            rd_q.push_back(r);
        end
        host.stop();
    endtask
    task automatic setst(input logic [7:0] v);
        xact(1, 48'h06, 0);
        xact(2, 48'({8'h01, v}), 0);
        if (write_guard_pin || !exp_st[7])
            exp_st = {v[7], 2'b00, v[4:2], 2'b00};
        chk_val(32'(status_byte), 32'(exp_st), "status");
    endtask
    function automatic logic prot_hit(input logic [23:0] a, input logic [2:0] p);
        case (p)
            3'h0: return 1'b0;
            3'h1: return a[18:16] == 3'h7;
            3'h2: return a[18:17] == 2'h3;
            3'h3: return a[18];
            default: return 1'b1;
        endcase
    endfunction
    task automatic prog(input logic [23:0] a, input logic [7:0] d,
        input logic write_enable_latch);
        logic hit;
        hit = !write_enable_latch || prot_hit(a, exp_st[4:2]);
        if (write_enable_latch)
            xact(1, 48'h06, 0);
        n_prog = 0;
        n_rej = 0;
        xact(5, 48'({8'h02, a, d}), 0);
        chk_val(32'(n_prog), 32'(!hit), "program");
        chk_val(32'(n_rej), 32'(hit), "refusal");
        if (!hit)
            chk_val({last_addr, last_wdata}, {a, d}, "data");
    endtask
    initial
    begin
        repeat (90000) @(posedge clk_sys);
        mismatches++;
        results();
    end
    initial
    begin
        logic [7:0] r;
        logic [23:0] a;
        repeat (2) @(negedge clk_sys);
        reset_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        chk_val(32'(status_byte), 32'h0c, "power-up");
        host.start();
        host.shift(8'h06, 5, r);
        host.stop();
        chk_val(32'(status_byte[1]), 0, "abort");
        setst(8'h00);
        prog(24'h000100, 8'h5a, 1'b0);
        write_guard_pin = 1'b0;
        setst(8'h80);
        xact(1, 48'h05, 2);
        chk_val({rd_q[0], rd_q[1]}, 16'h8080, "status read");
        setst(8'h0c);
        write_guard_pin = 1'b1;
        setst(8'h0c);
        for (int p = 0; p < 8; p++)
        begin
            setst(8'(p << 2));
            for (int j = 0; j < 4; j++)
            begin
                a = 24'($random(seed)) & 24'h07ffff;
                if (j < 2)
                    a = j == 0 ? 24'h06ffff : 24'h070000;
                prog(a, 8'($random(seed)), 1'b1);
            end
        end
        for (int i = 0; i < 5; i++)
        begin
            if (i < 2)
                setst(i == 0 ? 8'h04 : 8'h00);
            n_er = 0;
            xact(1, 48'h06, 0);
            xact(i < 3 ? 1 : 4, er_tab[i], 0);
            chk_val(32'(n_er), 32'(er_exp[i]), "erase");
            if (i > 0)
                chk_val(32'(status_byte[1]), 0, "latch");
        end
        n_prog = 0;
        r = 8'($random(seed));
        xact(1, 48'h06, 0);
        xact(6, {8'had, 24'h001230, ~r, r}, 0);
        chk_val(32'(n_prog), 2, "aai count");
        chk_val({last_addr, last_wdata}, {24'h001231, r}, "aai");
        chk_val(32'(status_byte[6]), 1, "aai flag");
        xact(1, 48'h04, 0);
        chk_val(32'(status_byte[6]), 0, "aai end");
        for (int i = 0; i < 3; i++)
        begin
            xact(1, 48'(md_op[i]), 0);
            chk_val(32'({ready_out_en, pause_pin_mode}), 32'(md_exp[i]), "mode");
        end
        xact(4, 48'h90000000, 1);
        chk_val(32'(rd_q[0]), 32'(MAKER), "maker");
        xact(4, 48'hab000001, 1);
        chk_val(32'(rd_q[0]), 32'(PART), "part");
        array_rdata = 8'($random(seed));
        xact(4, 48'h03012345, 1);
        // The stream has already fetched the next address after one byte.
        chk_val({last_addr, rd_q[0]}, {24'h012346, array_rdata}, "read");
        xact(5, 48'h0b02468000, 1);
        chk_val({last_addr, rd_q[0]}, {24'h024681, array_rdata}, "fast");
        results();
    end
endmodule // serial_flash_protect_cmd_decode_tb
`default_nettype wire

/* File: spi_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    // Clock.
    input wire logic clk_sys,
    // Link pins.
    output logic sel_n_pin,
    output logic sck_pin,
    output logic sdi_pin,
    input wire logic sdo_out,
    input wire logic sdo_oe_n
);
    initial
    begin
        sel_n_pin = 1'b1;
        sck_pin = 1'b0;
        sdi_pin = 1'b0;
    end
    task automatic gap(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic start;
        gap(1);
        sel_n_pin = 1'b0;
        gap(4);
    endtask
    // The reply is taken late in the high phase, after the device updated it.
    task automatic shift(input logic [7:0] tx, input int nb,
        output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - nb; i--)
        begin
            sdi_pin = tx[i];
            gap(4);
            sck_pin = 1'b1;
            gap(3);
            rx[i] = sdo_oe_n ? 1'bx : sdo_out;
            gap(1);
            sck_pin = 1'b0;
        end
    endtask
    task automatic stop;
        gap(4);
        sel_n_pin = 1'b1;
        sdi_pin = ~sdi_pin;
        gap(12);
    endtask
endmodule // spi_host_model
`default_nettype wire
